//--- design/dds_chirp_and_bpsk_control.sv
// Sweep, clear and binary phase-keying control around the phase accumulator.
// Assumes a byte-wide programming port and pins synchronous to clk.
`timescale 1ns/1ps
module dds_chirp_and_bpsk_control
  import dds_sweep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Programming port
  input wire logic [5:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_wr,
  input wire logic prog_rd,
  output logic [7:0] prog_rdata_q,
  // Hold in sweep mode, data bit in keying mode
  input wire logic keying_pin,
  // Update strobe pin, two-way
  input wire logic update_strobe_pin_in,
  output logic update_strobe_pin_out_q,
  output logic update_strobe_pin_oe_n_q,
  // Synthesis core
  output logic [FREQ_W-1:0] freq_word_q,
  output logic [FREQ_W-1:0] phase_accumulator_q,
  output logic [PHASE_W-1:0] phase_out_q
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  settings_s buf_q; // Written by the host
  settings_s act_q; // Committed copy steering the core
  logic [FREQ_W-1:0] frequency_accumulator_q; // Sweep offset from start word
  logic upd_in_q; // Previous update pin level
  logic upd_tick; // Internal update pulse
  logic ext_rise; // External update edge
  logic upd_evt; // Commit event
  logic freq_clear_pulse; // One-clock frequency clear
  logic both_clear; // Combined clear held
  logic is_sweep; // Sweep mode active
  logic ramp_run; // Dwell counter enable
  logic step_pulse; // Step request from dwell counter
  logic signed [49:0] cand; // Next sweep frequency, widened
  logic in_band; // Candidate between dc and Nyquist
  logic [7:0] rd_byte; // Read mux output
  pin_state_e pin_state_q; // Update pin driver state
  logic [2:0] pin_cnt_q; // Clocks left in high time

  // Decoded control bits of the committed copy
  assign is_sweep = act_q.control[CTL_MODE_LSB +: 2] == MODE_SWEEP;
  assign both_clear = act_q.control[CTL_BOTH_CLEAR_BIT];
  assign ext_rise = update_strobe_pin_in && !upd_in_q;
  assign upd_evt = act_q.control[CTL_INT_UPDATE_BIT] ? upd_tick : ext_rise;
  // The clear one-shot fires on every commit that carries the bit
  assign freq_clear_pulse = upd_evt && buf_q.control[CTL_FREQ_CLEAR_BIT];
  assign ramp_run = is_sweep && !keying_pin && !both_clear;

  // ----------------------------------------
  // Host writes into the buffer copy
  // ----------------------------------------
  // Writes never touch the committed copy, so clears leave settings intact
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buf_q <= '0;
      buf_q.control <= CONTROL_RESET;
      buf_q.update_count <= UPDCNT_RESET;
    end else if (prog_wr) begin
      if (prog_addr >= OFS_START_HI && prog_addr <= OFS_START_LO) begin
        buf_q.start_tuning_word[8*(OFS_START_LO-prog_addr) +: 8] <= prog_wdata;
      end else if (prog_addr >= OFS_STEP_HI && prog_addr <= OFS_STEP_LO) begin
        buf_q.frequency_step_word[8*(OFS_STEP_LO-prog_addr) +: 8] <= prog_wdata;
      end else if (prog_addr >= OFS_UPDCNT_HI && prog_addr <= OFS_UPDCNT_LO) begin
        buf_q.update_count[8*(OFS_UPDCNT_LO-prog_addr) +: 8] <= prog_wdata;
      end else if (prog_addr == OFS_INTERVAL_HI) begin
        buf_q.step_interval_count[19:16] <= prog_wdata[3:0];
      end else if (prog_addr > OFS_INTERVAL_HI && prog_addr <= OFS_INTERVAL_LO) begin
        buf_q.step_interval_count[8*(OFS_INTERVAL_LO-prog_addr) +: 8] <= prog_wdata;
      end else if (prog_addr == OFS_PHASE1_HI) begin
        buf_q.phase_offset1[13:8] <= prog_wdata[5:0];
      end else if (prog_addr == OFS_PHASE1_LO) begin
        buf_q.phase_offset1[7:0] <= prog_wdata;
      end else if (prog_addr == OFS_PHASE2_HI) begin
        buf_q.phase_offset2[13:8] <= prog_wdata[5:0];
      end else if (prog_addr == OFS_PHASE2_LO) begin
        buf_q.phase_offset2[7:0] <= prog_wdata;
      end else if (prog_addr == OFS_CONTROL) begin
        buf_q.control <= prog_wdata;
      end
    end
  end

  // ----------------------------------------
  // Read mux over the buffer copy
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (prog_addr >= OFS_START_HI && prog_addr <= OFS_START_LO) begin
      rd_byte = buf_q.start_tuning_word[8*(OFS_START_LO-prog_addr) +: 8];
    end else if (prog_addr >= OFS_STEP_HI && prog_addr <= OFS_STEP_LO) begin
      rd_byte = buf_q.frequency_step_word[8*(OFS_STEP_LO-prog_addr) +: 8];
    end else if (prog_addr >= OFS_UPDCNT_HI && prog_addr <= OFS_UPDCNT_LO) begin
      rd_byte = buf_q.update_count[8*(OFS_UPDCNT_LO-prog_addr) +: 8];
    end else if (prog_addr == OFS_INTERVAL_HI) begin
      rd_byte = {4'h0, buf_q.step_interval_count[19:16]};
    end else if (prog_addr > OFS_INTERVAL_HI && prog_addr <= OFS_INTERVAL_LO) begin
      rd_byte = buf_q.step_interval_count[8*(OFS_INTERVAL_LO-prog_addr) +: 8];
    end else if (prog_addr == OFS_PHASE1_HI) begin
      rd_byte = {2'h0, buf_q.phase_offset1[13:8]};
    end else if (prog_addr == OFS_PHASE1_LO) begin
      rd_byte = buf_q.phase_offset1[7:0];
    end else if (prog_addr == OFS_PHASE2_HI) begin
      rd_byte = {2'h0, buf_q.phase_offset2[13:8]};
    end else if (prog_addr == OFS_PHASE2_LO) begin
      rd_byte = buf_q.phase_offset2[7:0];
    end else if (prog_addr == OFS_CONTROL) begin
      rd_byte = buf_q.control;
    end
  end

  // Registered read data, held between reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_rdata_q <= 8'h00;
    end else if (prog_rd) begin
      prog_rdata_q <= rd_byte;
    end
  end

  // ----------------------------------------
  // Commit on update
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_q <= '0;
      act_q.control <= CONTROL_RESET;
      act_q.update_count <= UPDCNT_RESET;
    end else if (upd_evt) begin
      act_q <= buf_q;
    end
  end

  // External edge detector; pin is taken as synchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_in_q <= 1'b0;
    end else begin
      upd_in_q <= update_strobe_pin_in;
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  update_tick_timer #(.W(UPDCNT_W)) u_update_timer (
    .clk(clk),
    .resetn(resetn),
    .run(act_q.control[CTL_INT_UPDATE_BIT]),
    .reload_value(act_q.update_count),
    .tick_q(upd_tick)
  );

  // Restart only on a clear so an update alone lets the dwell finish
  ramp_step_timer #(.W(INTERVAL_W)) u_ramp_timer (
    .clk(clk),
    .resetn(resetn),
    .run(ramp_run),
    .restart(freq_clear_pulse || both_clear),
    .reload_value(act_q.step_interval_count),
    .step_q(step_pulse)
  );

  // ----------------------------------------
  // Frequency accumulator
  // ----------------------------------------
  // Sign-extended sum; the sign bit of the step sets the direction
  always_comb begin
    cand = $signed({2'b00, act_q.start_tuning_word})
      + $signed({{2{frequency_accumulator_q[47]}}, frequency_accumulator_q})
      + $signed({{2{act_q.frequency_step_word[47]}}, act_q.frequency_step_word});
    in_band = !cand[49] && cand[48:47] == 2'b00;
  end

  // A step that would leave dc..Nyquist is dropped, freezing at the edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frequency_accumulator_q <= '0;
    end else if (both_clear || freq_clear_pulse) begin
      frequency_accumulator_q <= '0;
    end else if (step_pulse && ramp_run && in_band) begin
      frequency_accumulator_q <= cand[47:0] - act_q.start_tuning_word;
    end
  end

  // ----------------------------------------
  // Tuning word, phase accumulator and offset
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freq_word_q <= '0;
    end else if (both_clear) begin
      freq_word_q <= '0;
    end else if (is_sweep) begin
      freq_word_q <= act_q.start_tuning_word + frequency_accumulator_q;
    end else begin
      freq_word_q <= act_q.start_tuning_word;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_accumulator_q <= '0;
    end else if (both_clear) begin
      phase_accumulator_q <= '0;
    end else begin
      phase_accumulator_q <= phase_accumulator_q + freq_word_q;
    end
  end

  // One phase word out; keying mode with the data pin high adds offset two, else offset one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_out_q <= '0;
    end else if (act_q.control[CTL_MODE_LSB +: 2] == MODE_BPSK && keying_pin) begin
      phase_out_q <= phase_accumulator_q[47:34] + act_q.phase_offset2;
    end else begin
      phase_out_q <= phase_accumulator_q[47:34] + act_q.phase_offset1;
    end
  end

  // ----------------------------------------
  // Update strobe pin driver
  // ----------------------------------------
  // Short update periods leave the pin high; it then no longer marks commits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_state_q <= PIN_IDLE;
      pin_cnt_q <= 3'h0;
      update_strobe_pin_out_q <= 1'b0;
      update_strobe_pin_oe_n_q <= 1'b1;
    end else begin
      update_strobe_pin_oe_n_q <= !act_q.control[CTL_INT_UPDATE_BIT];
      case (pin_state_q)
        PIN_IDLE: begin
          if (upd_tick) begin
            pin_state_q <= PIN_HIGH;
            pin_cnt_q <= UPD_HIGH_CYCLES;
            update_strobe_pin_out_q <= 1'b1;
          end
        end
        PIN_HIGH: begin
          if (upd_tick) begin
            pin_cnt_q <= UPD_HIGH_CYCLES;
          end else if (pin_cnt_q != 3'h0) begin
            pin_cnt_q <= pin_cnt_q - 3'h1;
          end else if (act_q.update_count >= UPD_MIN_COUNT) begin
            pin_state_q <= PIN_IDLE;
            update_strobe_pin_out_q <= 1'b0;
          end
        end
        default: begin
          pin_state_q <= PIN_IDLE;
          update_strobe_pin_out_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_commit_on_update: assert property (@(posedge clk) disable iff (!resetn)
    !upd_evt |=> act_q == $past(act_q))
    else $error("settings changed without an update");

  a_both_clear_zero: assert property (@(posedge clk) disable iff (!resetn)
    both_clear ##1 both_clear |-> freq_word_q == '0 && phase_accumulator_q == '0)
    else $error("combined clear did not hold accumulators at zero");

  a_clear_keeps_step: assert property (@(posedge clk) disable iff (!resetn)
    freq_clear_pulse |=> frequency_accumulator_q == '0
      && act_q.frequency_step_word == $past(buf_q.frequency_step_word))
    else $error("frequency clear failed or disturbed step word");

  a_hold_freezes: assert property (@(posedge clk) disable iff (!resetn)
    is_sweep && keying_pin && !upd_evt && !both_clear ##1 keying_pin
      |-> $stable(frequency_accumulator_q))
    else $error("sweep moved during hold");

  a_zero_step_still: assert property (@(posedge clk) disable iff (!resetn)
    act_q.frequency_step_word == '0 && !freq_clear_pulse && !both_clear
      |=> $stable(frequency_accumulator_q))
    else $error("zero step word changed the frequency");

  a_pin_high_eight: assert property (@(posedge clk) disable iff (!resetn)
    $rose(update_strobe_pin_out_q) |-> update_strobe_pin_out_q[*8])
    else $error("update pin high time shorter than eight clocks");

  // A step leaving dc..Nyquist must be dropped, so the sweep parks at the edge
  a_sweep_in_band: assert property (@(posedge clk) disable iff (!resetn)
    step_pulse && !in_band && !freq_clear_pulse && !both_clear
      |=> $stable(frequency_accumulator_q))
    else $error("sweep stepped outside the dc to Nyquist band");

endmodule

//--- design/dds_sweep_pkg.sv
// Constants, types and register map for the sweep and phase-keying control.
// Assumes one 200 MHz system clock and a byte-wide programming port.
package dds_sweep_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned FREQ_W = 48;
  localparam int unsigned PHASE_W = 14;
  localparam int unsigned INTERVAL_W = 20;
  localparam int unsigned UPDCNT_W = 32;

  // ----------------------------------------
  // Byte offsets, high byte first
  // ----------------------------------------
  localparam logic [5:0] OFS_PHASE1_HI = 6'h00;
  localparam logic [5:0] OFS_PHASE1_LO = 6'h01;
  localparam logic [5:0] OFS_PHASE2_HI = 6'h02;
  localparam logic [5:0] OFS_PHASE2_LO = 6'h03;
  localparam logic [5:0] OFS_START_HI = 6'h04;
  localparam logic [5:0] OFS_START_LO = 6'h09;
  localparam logic [5:0] OFS_STEP_HI = 6'h10;
  localparam logic [5:0] OFS_STEP_LO = 6'h15;
  localparam logic [5:0] OFS_UPDCNT_HI = 6'h16;
  localparam logic [5:0] OFS_UPDCNT_LO = 6'h19;
  localparam logic [5:0] OFS_INTERVAL_HI = 6'h1a;
  localparam logic [5:0] OFS_INTERVAL_LO = 6'h1c;
  localparam logic [5:0] OFS_CONTROL = 6'h1f;

  // ----------------------------------------
  // Control byte fields
  // ----------------------------------------
  localparam int unsigned CTL_INT_UPDATE_BIT = 0;
  localparam int unsigned CTL_BOTH_CLEAR_BIT = 1;
  localparam int unsigned CTL_FREQ_CLEAR_BIT = 2;
  localparam int unsigned CTL_MODE_LSB = 4;

  // Reset values: internal update on, single tone
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  localparam logic [31:0] UPDCNT_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Update strobe pin timing
  // ----------------------------------------
  localparam logic [2:0] UPD_HIGH_CYCLES = 3'h7; // Eight clocks high, counted 7..0
  localparam logic [31:0] UPD_MIN_COUNT = 32'h0000_0005;

  // Operating modes in the control byte
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_BPSK = 2'h1,
    MODE_SWEEP = 2'h2
  } mode_e;

  // Update strobe driver states, one-hot
  typedef enum logic [1:0] {
    PIN_IDLE = 2'b01,
    PIN_HIGH = 2'b10
  } pin_state_e;

  // One full set of programmable words
  typedef struct packed {
    logic [7:0] control;
    logic [FREQ_W-1:0] start_tuning_word;
    logic [FREQ_W-1:0] frequency_step_word;
    logic [INTERVAL_W-1:0] step_interval_count;
    logic [UPDCNT_W-1:0] update_count;
    logic [PHASE_W-1:0] phase_offset1;
    logic [PHASE_W-1:0] phase_offset2;
  } settings_s;

endpackage

//--- design/ramp_step_timer.sv
// Dwell countdown that paces frequency steps.
// Assumes the reload value is stable apart from update commits.
`timescale 1ns/1ps
module ramp_step_timer
  import dds_sweep_pkg::*;
#(
  parameter int unsigned W = INTERVAL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [W-1:0] reload_value,
  // Step pulse
  output logic step_q
);

  logic [W-1:0] count_q; // Remaining dwell clocks

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  // New count taken at zero or on restart, so a hold never cuts a dwell short
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      step_q <= 1'b0;
    end else if (restart) begin
      count_q <= reload_value;
      step_q <= 1'b0;
    end else if (run) begin
      if (count_q == '0) begin
        count_q <= reload_value;
        step_q <= 1'b1;
      end else begin
        count_q <= count_q - 1'b1;
        step_q <= 1'b0;
      end
    end else begin
      step_q <= 1'b0;
    end
  end

  // A step is never issued while stopped
  a_step_needs_run: assert property (@(posedge clk) disable iff (!resetn)
    step_q |-> $past(run) && !$past(restart))
    else $error("step pulse without running dwell counter");

  // Countdown reloads in the same clock as each step
  a_reload_at_step: assert property (@(posedge clk) disable iff (!resetn)
    step_q |-> count_q == $past(reload_value))
    else $error("dwell counter not reloaded at step");

endmodule

//--- design/update_tick_timer.sv
// Internal update countdown run at half the system clock rate.
// Assumes the reload value only changes at an update commit.
`timescale 1ns/1ps
module update_tick_timer
  import dds_sweep_pkg::*;
#(
  parameter int unsigned W = UPDCNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [W-1:0] reload_value,
  // Update tick
  output logic tick_q
);

  logic half_q; // Half-rate enable
  logic [W-1:0] count_q; // Remaining half-rate periods

  // ----------------------------------------
  // Half-rate enable
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= run ? ~half_q : 1'b0;
    end
  end

  // ----------------------------------------
  // Countdown, one tick every (N+1)*2 clocks
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else if (run && half_q) begin
      if (count_q == '0) begin
        count_q <= reload_value;
        tick_q <= 1'b1;
      end else begin
        count_q <= count_q - 1'b1;
        tick_q <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end

  // Ticks are at least two clocks apart
  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    tick_q |=> !tick_q)
    else $error("update ticks closer than two clocks");

endmodule

//--- testbench/host_model.sv
// Host controller model: programming port writes and reads, pin drive.
// Assumes the control block samples every input on the rising clk edge.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Programming port
  output logic [5:0] prog_addr,
  output logic [7:0] prog_wdata,
  output logic prog_wr,
  output logic prog_rd,
  input wire logic [7:0] prog_rdata_q,
  // Pins
  output logic keying_pin,
  output logic host_strobe
);
  // ----------------------------------------
  // Idle levels at time zero
  // ----------------------------------------
  initial begin
    prog_addr = 6'h00;
    prog_wdata = 8'h00;
    prog_wr = 1'b0;
    prog_rd = 1'b0;
    keying_pin = 1'b0;
    host_strobe = 1'b0;
  end

  // Multi-byte write, most significant byte at lowest address
  task automatic wr(input logic [5:0] a, input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      prog_addr <= a + 6'(i);
      prog_wdata <= v[8*(n-1-i) +: 8];
      prog_wr <= 1'b1;
    end
    @(posedge clk);
    prog_wr <= 1'b0;
    // Released data shows a changing pattern, not the last byte
    prog_wdata <= ~prog_wdata;
  endtask

  // Read strobe, data taken one edge later
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    prog_addr <= a;
    prog_rd <= 1'b1;
    @(posedge clk);
    prog_rd <= 1'b0;
    #1;
    d = prog_rdata_q;
  endtask

  // Level change on the hold or data pin
  task automatic set_key(input logic v);
    @(posedge clk);
    keying_pin <= v;
  endtask

  // External update pulse, two clocks high; commits settings while internal update is off
  task automatic strobe();
    @(posedge clk);
    host_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    host_strobe <= 1'b0;
  endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the sweep, clear and phase-keying control.
// Assumes the host model file is compiled first and one 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import dds_sweep_pkg::*;
  logic clk;
  logic resetn;
  logic [5:0] prog_addr;
  logic [7:0] prog_wdata;
  logic prog_wr;
  logic prog_rd;
  logic [7:0] prog_rdata_q;
  logic keying_pin;
  logic host_strobe;
  logic pin_in;
  logic pin_out;
  logic pin_oe_n;
  logic [FREQ_W-1:0] freq_q;
  logic [FREQ_W-1:0] acc_q;
  logic [PHASE_W-1:0] phase_q;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // Pin level: design drives it while its enable is low
  assign pin_in = pin_oe_n ? host_strobe : pin_out;

  // ----------------------------------------
  // Clock, timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end

  host_model host (.clk(clk), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_rdata_q(prog_rdata_q),
    .keying_pin(keying_pin), .host_strobe(host_strobe));

  dds_chirp_and_bpsk_control DUT (.clk(clk), .resetn(resetn), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_wr(prog_wr), .prog_rd(prog_rd),
    .prog_rdata_q(prog_rdata_q), .keying_pin(keying_pin),
    .update_strobe_pin_in(pin_in), .update_strobe_pin_out_q(pin_out),
    .update_strobe_pin_oe_n_q(pin_oe_n), .freq_word_q(freq_q),
    .phase_accumulator_q(acc_q), .phase_out_q(phase_q));

  // ----------------------------------------
  // Compare and wait helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cyc(input string what, input int e, input int g);
    n_tests++;
    if (g != e) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask
  // Cycles until the tuning word moves, bounded
  task automatic wait_step(output int n);
    logic [47:0] p;
    p = freq_q;
    n = 0;
    while (freq_q === p && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wait_val(input logic [47:0] v);
    for (int i = 0; i < 200 && freq_q !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk("start word", v, freq_q);
  endtask
  // Reference sweep: start, then one step word per dwell of N+1 clocks
  task automatic run_sweep(input logic [47:0] s, input logic [47:0] d, input int nd);
    int n;
    logic [47:0] e_q[$];
    for (int k = 1; k <= 4; k++) begin
      e_q.push_back(s + 48'(k) * d);
    end
    wait_val(s);
    wait_step(n);
    chk("first step", e_q.pop_front(), freq_q);
    repeat (3) begin
      wait_step(n);
      chk("step word", e_q.pop_front(), freq_q);
      chk_cyc("dwell", nd + 1, n);
    end
  endtask
  task automatic wait_rise(output int n);
    logic p;
    n = 0;
    do begin
      p = pin_in;
      @(posedge clk);
      #1;
      n++;
    end while (!(p === 1'b0 && pin_in === 1'b1) && n < 500);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [47:0] s;
    logic [47:0] d;
    logic [47:0] v;
    logic [7:0] b;
    logic [13:0] o1;
    logic [13:0] o2;
    int n;
    resetn = 1'b0;
    void'($urandom(32'h0921));
    s = {4'h3, 12'($urandom), 32'($urandom)};
    d = {24'h0, 8'h01, 16'($urandom)};
    o1 = 14'($urandom);
    o2 = 14'($urandom);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // Program sweep; the internal update still running commits it
    host.wr(OFS_START_HI, 6, s);
    host.wr(OFS_STEP_HI, 6, d);
    host.wr(OFS_INTERVAL_HI, 3, 48'h3);
    host.wr(OFS_CONTROL, 1, 48'h24);
    host.rd(OFS_START_LO, b);
    chk("start low byte", {40'h0, s[7:0]}, {40'h0, b});
    host.rd(6'h3f, b);
    chk("unmapped byte", 48'h0, {40'h0, b});
    run_sweep(s, d, 3);
    // Hold freezes, release resumes by one step
    host.set_key(1'b1);
    repeat (4) @(posedge clk);
    #1;
    v = freq_q;
    repeat (20) @(posedge clk);
    #1;
    chk("held word", v, freq_q);
    host.set_key(1'b0);
    wait_step(n);
    chk("resumed word", v + d, freq_q);
    // Downward sweep restarts at start with held clear bit
    host.wr(OFS_STEP_HI, 6, -d);
    host.strobe();
    run_sweep(s, -d, 3);
    // Zero step, then a write that waits for the update
    host.wr(OFS_STEP_HI, 6, 48'h0);
    host.strobe();
    wait_val(s);
    repeat (30) @(posedge clk);
    #1;
    chk("zero step", s, freq_q);
    v = s ^ 48'h0000_0001_0000;
    host.wr(OFS_START_HI, 6, v);
    repeat (20) @(posedge clk);
    #1;
    chk("no update yet", s, freq_q);
    host.strobe();
    wait_val(v);
    // Combined clear, reprogram while cleared
    host.wr(OFS_CONTROL, 1, 48'h26);
    host.strobe();
    repeat (4) @(posedge clk);
    #1;
    chk("cleared freq", 48'h0, freq_q);
    chk("cleared phase", 48'h0, acc_q);
    host.wr(OFS_START_HI, 6, s);
    host.wr(OFS_STEP_HI, 6, d);
    host.strobe();
    repeat (4) @(posedge clk);
    #1;
    chk("still cleared", 48'h0, freq_q);
    host.wr(OFS_CONTROL, 1, 48'h24);
    host.strobe();
    run_sweep(s, d, 3);
    // Phase keying with a still phase accumulator
    host.wr(OFS_START_HI, 6, 48'h0);
    host.wr(OFS_PHASE1_HI, 2, {34'h0, o1});
    host.wr(OFS_PHASE2_HI, 2, {34'h0, o2});
    host.wr(OFS_CONTROL, 1, 48'h12);
    host.strobe();
    host.wr(OFS_CONTROL, 1, 48'h10);
    host.strobe();
    for (int k = 0; k < 2; k++) begin
      host.set_key(k[0]);
      repeat (4) @(posedge clk);
      #1;
      chk("phase offset", {34'h0, k ? o2 : o1}, {34'h0, phase_q});
    end
    // Single tone ignores the data pin; offset one rewritten in place
    host.wr(OFS_CONTROL, 1, 48'h00);
    host.wr(OFS_PHASE1_HI, 2, {34'h0, ~o1});
    host.strobe();
    repeat (4) @(posedge clk);
    #1;
    chk("rewritten offset", {34'h0, ~o1}, {34'h0, phase_q});
    // Internal update counter, count 7 gives 16 clocks
    host.wr(OFS_UPDCNT_HI, 4, 48'h7);
    host.wr(OFS_CONTROL, 1, 48'h01);
    host.strobe();
    wait_rise(n);
    chk("pin driven", 48'h0, {47'h0, pin_oe_n});
    wait_rise(n);
    chk_cyc("update period", 16, n);
    // Sawtooth: held clear bit restarts the sweep at every internal update
    host.set_key(1'b0);
    host.wr(OFS_START_HI, 6, s);
    host.wr(OFS_CONTROL, 1, 48'h25);
    wait_rise(n);
    for (int k = 0; k < 2; k++) begin
      wait_rise(n);
      repeat (13) @(posedge clk);
      #1;
      chk("sawtooth word", s + d + d, freq_q);
    end
    // A negative step as large as the start word parks the sweep at dc
    host.wr(OFS_STEP_HI, 6, -s);
    wait_rise(n);
    wait_rise(n);
    repeat (13) @(posedge clk);
    #1;
    chk("band floor", 48'h0, freq_q);
    summarize();
  end
endmodule
